// file: hdl/stp_pkg.sv
// constants, types and decoding shared by the stepper drive files
package stp_pkg;

  // ==========================================================
  // clock and pwm timing
  localparam int CLK_HZ = 20_000_000;
  localparam int PWM_HZ = 40_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] PWM_LAST = CNT_W'(PWM_PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] PWM_FULL = CNT_W'(PWM_PERIOD_CYC);

  // ==========================================================
  // widths
  localparam int CMD_W = 10;
  localparam int CUR_W = 12;
  localparam int DUTY_W = CNT_W;
  localparam int STEP_W = 8;
  localparam int NWIND = 2;

  // ==========================================================
  // amplitude loop and decay limits
  localparam logic [DUTY_W-1:0] DUTY_INC = 9'h001;
  localparam logic [DUTY_W-1:0] RST_DUTY = 9'h000;
  localparam logic [CUR_W-1:0] RST_PEAK = 12'h000;
  localparam logic [CNT_W-1:0] RST_CNT = 9'h000;
  localparam logic [STEP_W-1:0] RST_STEP = 8'h00;
  localparam logic [2:0] GRAN_MAX = 3'h6;
  localparam logic [3:0] REVERSE_MAX_PERIODS = 4'h4;
  localparam logic [3:0] RST_REV = 4'h0;

  // ==========================================================
  // modes
  typedef enum logic {
    STP_FIXED_VOLTAGE,
    STP_FIXED_CURRENT
  } stp_method_t;

  typedef enum logic {
    STP_FIXED_DECAY,
    STP_ALTERNATE_DECAY
  } stp_decay_use_t;

  typedef enum logic [2:0] {
    STP_D_FAST,
    STP_D_REVERSE,
    STP_D_SLOW_L_DIODE,
    STP_D_SLOW_H_DIODE,
    STP_D_SLOW_L_MOSFET,
    STP_D_SLOW_H_MOSFET
  } stp_decay_t;

  // ==========================================================
  // decoding
  // illegal codes fall back to low side mosfet recirculation
  function automatic stp_decay_t stp_legal_decay(input logic [2:0] code);
    stp_legal_decay = (code > 3'h5) ? STP_D_SLOW_L_MOSFET : stp_decay_t'(code);
  endfunction : stp_legal_decay

  function automatic logic stp_is_fast(input stp_decay_t d);
    stp_is_fast = (d == STP_D_FAST) || (d == STP_D_REVERSE);
  endfunction : stp_is_fast

endpackage : stp_pkg

// file: hdl/stp_bridge_gate.sv
// gate pattern of one h-bridge for the chosen decay mode
`timescale 1ns/1ps
`default_nettype none
module stp_bridge_gate
  import stp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pattern select
  input wire stp_decay_t decay,
  input wire logic pwm_on,
  input wire logic negative,
  // gates
  output logic left_high_gate,
  output logic left_low_gate,
  output logic right_high_gate,
  output logic right_low_gate
);

  // ==========================================================
  // pattern for the positive direction
  logic dh;
  logic dl;
  logic oh;
  logic ol;

  always_comb begin
    dh = 1'b0;
    dl = 1'b0;
    oh = 1'b0;
    ol = 1'b0;
    unique case (decay)
      STP_D_FAST: begin
        dh = pwm_on;
        oh = pwm_on;
      end
      STP_D_REVERSE: begin
        dh = pwm_on;
        dl = pwm_on;
        oh = pwm_on;
        ol = pwm_on;
      end
      STP_D_SLOW_L_DIODE: begin
        dh = pwm_on;
        oh = 1'b1;
      end
      STP_D_SLOW_H_DIODE: begin
        dl = pwm_on;
        ol = 1'b1;
      end
      STP_D_SLOW_L_MOSFET: begin
        dh = pwm_on;
        dl = pwm_on;
        oh = 1'b1;
        ol = 1'b0;
      end
      STP_D_SLOW_H_MOSFET: begin
        oh = pwm_on;
        ol = pwm_on;
        dh = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // registered gates, sides swapped for negative current
  always_ff @(posedge clk) begin
    if (!nrst) begin
      left_high_gate <= 1'b0;
      left_low_gate <= 1'b0;
      right_high_gate <= 1'b0;
      right_low_gate <= 1'b0;
    end else begin
      left_high_gate <= negative ? oh : dh;
      left_low_gate <= negative ? ol : dl;
      right_high_gate <= negative ? dh : oh;
      right_low_gate <= negative ? dl : ol;
    end
  end

endmodule : stp_bridge_gate
`default_nettype wire

// file: hdl/stp_open_loop_drive.sv
// open loop voltage and amplitude regulated drive of a two winding stepper
// What this block does
// - voltage mode: duty from command times rated duty, no feedback
// - every granularity, table values are voltages
// - fixed-voltage selector value picks voltage method
// - fixed-current selector value picks amplitude method
// - correct duty once per electrical period
// - capture peak current of both windings
// - peak below set point: raise duty
// - peak above: lower, not below rated
// - only amplitude regulated, shape stays open loop
// - fast decay: highs pwm, lows zero
// - fast decay off time: all switches off
// - reverse decay counts as fast decay for sensing and status
// - reverse decay kept short, limited periods
// - fixed use: one of six modes
// - alternate use: switch between two modes
// - fast decay: shunt current always valid
// - fixed uses primary, alternate toggles both
// - reverse decay: all four gates pwm
// - slow low mosfet: opposite high one
// - granularity 0..6 gives 4..256 steps
`timescale 1ns/1ps
`default_nettype none
module stp_open_loop_drive
  import stp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire stp_method_t control_method_select,
  input wire stp_decay_use_t decay_use_select,
  input wire logic [2:0] primary_decay_choice,
  input wire logic [2:0] secondary_decay_choice,
  input wire logic [2:0] microstep_granularity,
  input wire logic [DUTY_W-1:0] rated_duty,
  input wire logic [CUR_W-1:0] current_setpoint,
  // waveform commands, one per winding except the shared step_tick
  input wire logic step_tick,
  input wire logic [NWIND*CMD_W-1:0] winding_level,
  input wire logic [NWIND-1:0] winding_negative,
  input wire logic [NWIND-1:0] secondary_request,
  // shunt current feedback
  input wire logic current_sample_valid,
  input wire logic [NWIND*CUR_W-1:0] shunt_current,
  // gates
  output logic [NWIND-1:0] left_high_gate,
  output logic [NWIND-1:0] left_low_gate,
  output logic [NWIND-1:0] right_high_gate,
  output logic [NWIND-1:0] right_low_gate,
  // status
  output logic [DUTY_W-1:0] amplitude_duty,
  output logic [CUR_W-1:0] last_peak_current,
  output logic period_done,
  output logic [NWIND-1:0] current_observable,
  output logic [2*NWIND-1:0] active_decay_code,
  output logic pwm_period_start
);

  // ==========================================================
  // helpers
  function automatic logic [CUR_W-1:0] mag(input logic [CUR_W-1:0] x);
    mag = x[CUR_W-1] ? CUR_W'(-x) : x;
  endfunction : mag

  function automatic logic [STEP_W-1:0] last_step(input logic [2:0] g);
    logic [2:0] gs;
    logic [STEP_W:0] n;
    gs = (g > GRAN_MAX) ? GRAN_MAX : g;
    n = (STEP_W+1)'(4) << gs;
    last_step = STEP_W'(n - (STEP_W+1)'(1));
  endfunction : last_step

  // ==========================================================
  // pwm carrier
  logic [CNT_W-1:0] pwm_cnt;
  logic boundary;

  assign boundary = (pwm_cnt == PWM_LAST);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_cnt <= RST_CNT;
    end else if (boundary) begin
      pwm_cnt <= RST_CNT;
    end else begin
      pwm_cnt <= pwm_cnt + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_period_start <= 1'b0;
    end else begin
      pwm_period_start <= boundary;
    end
  end

  // ==========================================================
  // step position inside one electrical period
  logic [STEP_W-1:0] step_pos;
  logic period_end;

  // a granularity cut mid period closes it on the next tick
  assign period_end = step_tick && (step_pos >= last_step(microstep_granularity));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      step_pos <= RST_STEP;
    end else if (period_end) begin
      step_pos <= RST_STEP;
    end else if (step_tick) begin
      step_pos <= step_pos + 8'h01;
    end
  end

  // ==========================================================
  // peak capture over one electrical period
  logic [NWIND-1:0] obs;
  logic [CUR_W-1:0] peak;
  logic [CUR_W-1:0] next_peak;

  always_comb begin
    next_peak = peak;
    for (int w = 0; w < NWIND; w++) begin
      if (current_sample_valid && obs[w] &&
          mag(shunt_current[w*CUR_W +: CUR_W]) > next_peak) begin
        next_peak = mag(shunt_current[w*CUR_W +: CUR_W]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      peak <= RST_PEAK;
    end else if (period_end) begin
      peak <= RST_PEAK;
    end else begin
      peak <= next_peak;
    end
  end

  // one cycle pulse marking the step that closed the period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      period_done <= 1'b0;
    end else begin
      period_done <= period_end;
    end
  end

  // the closing sample still belongs to the period it ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      last_peak_current <= RST_PEAK;
    end else if (period_end) begin
      last_peak_current <= next_peak;
    end
  end

  // ==========================================================
  // amplitude loop
  logic [DUTY_W-1:0] next_amp;

  always_comb begin
    next_amp = amplitude_duty;
    // out of reset or under the floor, restart from rated duty
    if (control_method_select == STP_FIXED_VOLTAGE) begin
      next_amp = rated_duty;
    end else if (amplitude_duty < rated_duty) begin
      next_amp = rated_duty;
    end else if (period_end) begin
      if (next_peak < current_setpoint && amplitude_duty < PWM_FULL) begin
        next_amp = amplitude_duty + DUTY_INC;
      end else if (next_peak > current_setpoint &&
                   amplitude_duty >= rated_duty + DUTY_INC) begin
        next_amp = amplitude_duty - DUTY_INC;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      amplitude_duty <= RST_DUTY;
    end else begin
      amplitude_duty <= next_amp;
    end
  end

  // ==========================================================
  // per winding drive
  genvar gw;
  generate
    for (gw = 0; gw < NWIND; gw++) begin : g_wind
      logic [CMD_W-1:0] level;
      logic [CMD_W+DUTY_W-1:0] product;
      logic [DUTY_W-1:0] on_cycles;
      logic negative;
      stp_decay_t wanted;
      stp_decay_t decay;
      logic [3:0] rev_run;
      logic pwm_on;

      assign level = winding_level[gw*CMD_W +: CMD_W];
      // table shape scaled by amplitude only
      assign product = level * amplitude_duty;

      always_comb begin
        wanted = stp_legal_decay(primary_decay_choice);
        if (decay_use_select == STP_ALTERNATE_DECAY && secondary_request[gw]) begin
          wanted = stp_legal_decay(secondary_decay_choice);
        end
        // zero level: fast decay drains the winding quickest
        if (level == 10'h000) begin
          wanted = STP_D_FAST;
        end
        if (wanted == STP_D_REVERSE && rev_run >= REVERSE_MAX_PERIODS) begin
          wanted = STP_D_FAST;
        end
      end

      // latched only at the wrap, so no gate pulse is cut short
      always_ff @(posedge clk) begin
        if (!nrst) begin
          on_cycles <= RST_DUTY;
          negative <= 1'b0;
          decay <= STP_D_SLOW_L_MOSFET;
        end else if (boundary) begin
          on_cycles <= product[CMD_W+DUTY_W-1:CMD_W];
          negative <= winding_negative[gw];
          decay <= wanted;
        end
      end

      // fast periods keep the count, so reverse cannot restart through them
      always_ff @(posedge clk) begin
        if (!nrst) begin
          rev_run <= RST_REV;
        end else if (boundary) begin
          if (wanted == STP_D_REVERSE) begin
            rev_run <= rev_run + 4'h1;
          end else if (wanted != STP_D_FAST) begin
            rev_run <= RST_REV;
          end
        end
      end

      assign pwm_on = (pwm_cnt < on_cycles);
      assign obs[gw] = stp_is_fast(decay) || pwm_on;

      // each winding owns its status flops, the ports only gather them
      logic obs_q;
      logic [1:0] code_q;

      always_ff @(posedge clk) begin
        if (!nrst) begin
          obs_q <= 1'b0;
        end else begin
          obs_q <= obs[gw];
        end
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          code_q <= 2'h0;
        end else begin
          code_q <= {stp_is_fast(decay), decay == STP_D_REVERSE};
        end
      end

      assign current_observable[gw] = obs_q;
      assign active_decay_code[2*gw +: 2] = code_q;

      stp_bridge_gate u_bridge (
        .clk(clk),
        .nrst(nrst),
        .decay(decay),
        .pwm_on(pwm_on),
        .negative(negative),
        .left_high_gate(left_high_gate[gw]),
        .left_low_gate(left_low_gate[gw]),
        .right_high_gate(right_high_gate[gw]),
        .right_low_gate(right_low_gate[gw])
      );
    end
  endgenerate

endmodule : stp_open_loop_drive
`default_nettype wire

// file: tb/stp_chk_assertions.sv
// port assertions for the stepper drive
`timescale 1ns/1ps
`default_nettype none
module stp_chk
  import stp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire stp_method_t control_method_select,
  input wire logic [DUTY_W-1:0] rated_duty,
  // gates
  input wire logic [NWIND-1:0] left_high_gate,
  input wire logic [NWIND-1:0] left_low_gate,
  input wire logic [NWIND-1:0] right_high_gate,
  input wire logic [NWIND-1:0] right_low_gate,
  // status
  input wire logic [DUTY_W-1:0] amplitude_duty,
  input wire logic period_done,
  input wire logic [NWIND-1:0] current_observable,
  input wire logic [2*NWIND-1:0] active_decay_code,
  input wire logic pwm_period_start
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [CNT_W-1:0] gap;
  logic seen;
  always_ff @(posedge clk) begin
    if (!nrst || pwm_period_start) gap <= RST_CNT;
    else gap <= gap + 9'h001;
  end
  always_ff @(posedge clk) begin
    if (!nrst) seen <= 1'b0;
    else if (pwm_period_start) seen <= 1'b1;
  end
  sequence s_w0(logic [1:0] c);
    (active_decay_code[1:0] == c) [*3];
  endsequence
  // ==========================================================
  // properties
  property p_fast_lows;
    s_w0(2'h2) |-> !left_low_gate[0] && !right_low_gate[0];
  endproperty
  a_fast_lows: assert property (p_fast_lows) else $error("fast decay low gate on");
  property p_rev_all;
    s_w0(2'h3) |-> left_high_gate[0] == left_low_gate[0] && left_high_gate[0] == right_high_gate[0]
      && right_high_gate[0] == right_low_gate[0];
  endproperty
  a_rev_all: assert property (p_rev_all) else $error("reverse gates differ");
  property p_obs;
    active_decay_code[1] [*3] |-> current_observable[0];
  endproperty
  a_obs: assert property (p_obs) else $error("fast decay current hidden");
  property p_done_pulse;
    period_done |=> !period_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("period end too long");
  property p_pwm_gap;
    pwm_period_start && seen |-> gap == 9'h1F3;
  endproperty
  a_pwm_gap: assert property (p_pwm_gap) else $error("pwm period length");
  property p_volt_duty;
    $past(nrst) && control_method_select == STP_FIXED_VOLTAGE
      && $past(control_method_select) == STP_FIXED_VOLTAGE |-> amplitude_duty == $past(rated_duty);
  endproperty
  a_volt_duty: assert property (p_volt_duty) else $error("voltage mode duty moved");
  property p_duty_step;
    ($past(nrst) && $past(nrst, 2) && control_method_select == STP_FIXED_CURRENT
      && $past(control_method_select) == STP_FIXED_CURRENT && rated_duty == $past(rated_duty, 2)
      && $changed(amplitude_duty)) |-> period_done && (amplitude_duty - $past(amplitude_duty)
      == 9'h001 || $past(amplitude_duty) - amplitude_duty == 9'h001);
  endproperty
  a_duty_step: assert property (p_duty_step) else $error("duty step wrong");
  property p_duty_floor;
    period_done && control_method_select == STP_FIXED_CURRENT |-> amplitude_duty >= rated_duty;
  endproperty
  a_duty_floor: assert property (p_duty_floor) else $error("duty below floor");
endmodule : stp_chk
bind stp_open_loop_drive stp_chk u_chk (.clk(clk), .nrst(nrst),
  .control_method_select(control_method_select), .rated_duty(rated_duty),
  .left_high_gate(left_high_gate), .left_low_gate(left_low_gate),
  .right_high_gate(right_high_gate), .right_low_gate(right_low_gate),
  .amplitude_duty(amplitude_duty), .period_done(period_done),
  .current_observable(current_observable), .active_decay_code(active_decay_code),
  .pwm_period_start(pwm_period_start));
`default_nettype wire

// file: tb/stp_bridge_model.sv
// shunt current model of the two bridges and windings
`timescale 1ns/1ps
`default_nettype none
module stp_bridge_model
  import stp_pkg::*;
#(
  parameter logic [CUR_W-1:0] AMP = 12'h100
)(
  // clock
  input wire logic clk,
  // gates
  input wire logic [NWIND-1:0] left_high_gate,
  input wire logic [NWIND-1:0] left_low_gate,
  input wire logic [NWIND-1:0] right_high_gate,
  input wire logic [NWIND-1:0] right_low_gate,
  // shunt sense
  output logic current_sample_valid,
  output var logic [NWIND*CUR_W-1:0] shunt_current = '0
);
  assign current_sample_valid = 1'b1;
  always @(posedge clk) begin
    for (int w = 0; w < NWIND; w++) begin
      // driven winding shows positive, diode decay negative, recirculation none
      if (left_high_gate[w] && right_high_gate[w] && !left_low_gate[w] && !right_low_gate[w])
        shunt_current[w*CUR_W +: CUR_W] <= AMP;
      else if (!left_high_gate[w] && !right_high_gate[w] && !left_low_gate[w] && !right_low_gate[w])
        shunt_current[w*CUR_W +: CUR_W] <= -AMP;
      else
        shunt_current[w*CUR_W +: CUR_W] <= '0;
    end
  end
endmodule : stp_bridge_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the stepper drive
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import stp_pkg::*;
  // ==========================================================
  // stimulus and wiring
  localparam int ON = (512 * 400) >> 10;
  localparam int P = PWM_PERIOD_CYC;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  stp_method_t meth = STP_FIXED_VOLTAGE;
  stp_decay_use_t dsel = STP_FIXED_DECAY;
  logic [2:0] prim = 3'h4;
  logic [2:0] sec = 3'h0;
  logic [2:0] gran = 3'h0;
  logic [8:0] rated = 9'h190;
  logic [11:0] setp = 12'h200;
  logic tick = 1'b0;
  logic [19:0] lvl = 20'h8_0200;
  logic [1:0] neg = 2'h2;
  logic [1:0] sreq = 2'h0;
  wire logic vld;
  wire logic [23:0] shunt;
  wire logic [1:0] lh, ll, rh, rl;
  wire logic [8:0] duty;
  wire logic [11:0] peak;
  wire logic done, pst;
  int n_errors = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  stp_open_loop_drive DUT (.clk(clk), .nrst(nrst), .control_method_select(meth),
    .decay_use_select(dsel), .primary_decay_choice(prim), .secondary_decay_choice(sec),
    .microstep_granularity(gran), .rated_duty(rated), .current_setpoint(setp),
    .step_tick(tick), .winding_level(lvl), .winding_negative(neg), .secondary_request(sreq),
    .current_sample_valid(vld), .shunt_current(shunt), .left_high_gate(lh),
    .left_low_gate(ll), .right_high_gate(rh), .right_low_gate(rl), .amplitude_duty(duty),
    .last_peak_current(peak), .period_done(done), .current_observable(),
    .active_decay_code(), .pwm_period_start(pst));
  stp_bridge_model u_model (.clk(clk), .left_high_gate(lh), .left_low_gate(ll),
    .right_high_gate(rh), .right_low_gate(rl), .current_sample_valid(vld), .shunt_current(shunt));
  // ==========================================================
  // shared tasks
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_start(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        cyc(1);
        k++;
      end while (pst !== 1'b1 && k < 600);
      if (k >= 600) begin
        n_errors++;
        close_out();
      end
    end
  endtask : wait_start
  // gate on-counts over one pwm period; winding 1 runs with sides exchanged
  task automatic pat(input int c0, input int c1, input int n);
    int cnt[8];
    int e[6][4] = '{'{ON, 0, ON, 0}, '{ON, ON, ON, ON}, '{ON, 0, P, 0}, '{0, ON, 0, P},
      '{ON, ON, P, 0}, '{P, 0, ON, ON}};
    cnt = '{default: 0};
    wait_start(n);
    repeat (P) begin
      cyc(1);
      for (int w = 0; w < 2; w++) begin
        cnt[w*4] += lh[w];
        cnt[w*4+1] += ll[w];
        cnt[w*4+2] += rh[w];
        cnt[w*4+3] += rl[w];
      end
    end
    for (int k = 0; k < 4; k++) begin
      chk("gate count w0", 12'(e[c0][k]), 12'(cnt[k]));
      chk("gate count w1", 12'(e[c1][(k+2)%4]), 12'(cnt[4+k]));
    end
  endtask : pat
  task automatic period(input int n, input logic [11:0] exp_duty);
    for (int k = 0; k < n; k++) begin
      cyc(150);
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      chk("period end", 12'(k == n - 1), {11'h000, done});
      cyc(1);
    end
    chk("duty", exp_duty, {3'h0, duty});
    if (meth == STP_FIXED_CURRENT) chk("peak", 12'h100, peak);
  endtask : period
  // ==========================================================
  // scenarios
  task automatic t_modes;
    for (int c = 0; c < 7; c++) begin
      prim = 3'(c);
      pat((c == 6) ? 4 : c, (c == 6) ? 4 : c, 2);
    end
  endtask : t_modes
  task automatic t_rev_limit;
    prim = 3'h1;
    pat(0, 0, 7);
  endtask : t_rev_limit
  task automatic t_alt;
    prim = 3'h4;
    dsel = STP_ALTERNATE_DECAY;
    sreq = 2'h2;
    pat(4, 0, 2);
    dsel = STP_FIXED_DECAY;
    pat(4, 4, 2);
  endtask : t_alt
  task automatic t_amp;
    meth = STP_FIXED_CURRENT;
    prim = 3'h0;
    period(4, 12'h191);
    setp = 12'h080;
    period(4, 12'h190);
    period(4, 12'h190);
    gran = 3'h1;
    period(8, 12'h190);
    meth = STP_FIXED_VOLTAGE;
    setp = 12'h200;
    gran = 3'h0;
    period(4, 12'h190);
  endtask : t_amp
  initial begin
    cyc(20);
    chk("gates in reset", 12'h000, {4'h0, lh, ll, rh, rl});
    nrst = 1'b1;
    cyc(2);
    chk("duty after reset", 12'h190, {3'h0, duty});
    t_modes();
    t_rev_limit();
    t_alt();
    t_amp();
    close_out();
  end
endmodule : testbench
`default_nettype wire
